// ### hdl/sac_pkg.sv
// Constants shared by the step attenuator control logic.
// Assumes a 200 MHz system clock and a 32-bit AXI4-Lite register port.
package sac_pkg;
  localparam int SAC_ATT_W = 7;
  localparam int SAC_WORD_W = 8;
  localparam int SAC_SHIFT_W = 16;
  localparam int SAC_ADDR_W = 3;
  localparam int SAC_CNT_W = 17;
  localparam int SAC_ADDR_LSB = 8;
  localparam logic [6:0] SAC_ATT_MAX = 7'h7F;
  localparam logic [6:0] SAC_ATT_MIN = 7'h00;
  localparam int SAC_CLK_MHZ = 200;
  localparam int SAC_POWERUP_US = 400;
  localparam int SAC_POWERUP_CYC = SAC_POWERUP_US * SAC_CLK_MHZ;
  localparam int SAC_INIT_CYC = 3;
  localparam int SAC_AXI_AW = 8;
  localparam logic [7:0] SAC_REG_CTRL = 8'h00;
  localparam logic [7:0] SAC_REG_STATUS = 8'h04;
  localparam logic [7:0] SAC_REG_SHIFT = 8'h08;
  localparam logic [1:0] SAC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SAC_RESP_SLVERR = 2'h2;
  localparam int SAC_CTRL_HOLD_BIT = 0;
  localparam int SAC_ST_WORD7_BIT = 7;
  localparam int SAC_ST_SERIAL_BIT = 8;
  localparam int SAC_ST_BUSY_BIT = 9;
  localparam logic [31:0] SAC_CTRL_RESET = 32'h0000_0000;
  typedef enum logic [1:0] {SAC_ST_INIT, SAC_ST_HOLD, SAC_ST_RUN} sac_state_t;
endpackage

// ### hdl/sac_sync2.sv
// Two-flop synchroniser for a bundle of independent pin levels.
// Assumes each bit is a slow level; bits are not coherent with one another.
`timescale 1ns/1ps
`default_nettype none
module sac_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ### hdl/sac_step_attenuator.sv
// Control logic of a 7-bit step attenuator: parallel, latched parallel and
// addressable serial programming, plus an AXI4-Lite view for software.
// Assumes all pins are asynchronous to clk; the serial clock is sampled.
`timescale 1ns/1ps
`default_nettype none
module sac_step_attenuator #(
  parameter int POWERUP_CYCLES = sac_pkg::SAC_POWERUP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic serial_clock,
  input wire logic serial_data,
  input wire logic latch_strobe,
  input wire logic mode_select,
  input wire logic [sac_pkg::SAC_ATT_W-1:0] parallel_control_inputs,
  input wire logic address_pin_bit0,
  input wire logic address_pin_bit1,
  input wire logic address_pin_bit2,
  input wire logic parallel_pins_floating,
  output logic [sac_pkg::SAC_ATT_W-1:0] attenuation_state,
  input wire logic [sac_pkg::SAC_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sac_pkg::SAC_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import sac_pkg::*;

  localparam int PIN_W = 15;

  logic [PIN_W-1:0] pins_async;
  logic [PIN_W-1:0] pins_s;
  logic sclk_s;
  logic sdata_s;
  logic le_s;
  logic serial_mode_s;
  logic [SAC_ATT_W-1:0] par_s;
  logic [SAC_ADDR_W-1:0] addr_s;
  logic float_s;
  logic [SAC_ATT_W-1:0] par_eff;
  logic sclk_d_r;
  logic le_d_r;
  logic sclk_rise;
  logic le_rise;
  logic [SAC_SHIFT_W-1:0] shreg_r;
  logic [SAC_WORD_W-1:0] word_r;
  logic [SAC_CNT_W-1:0] cnt_r;
  sac_state_t state_r;
  logic running;
  logic addr_match;
  logic direct_follow;
  logic [31:0] ctrl_r;
  logic hold_upd;
  logic aw_got_r;
  logic w_got_r;
  logic [SAC_AXI_AW-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  // Decodes a register offset; returns 2'd0 ctrl, 1 status, 2 shift, 3 none.
  function automatic logic [1:0] reg_sel(input logic [SAC_AXI_AW-1:0] a);
    if (a == SAC_REG_CTRL) begin
      reg_sel = 2'd0;
    end else if (a == SAC_REG_STATUS) begin
      reg_sel = 2'd1;
    end else if (a == SAC_REG_SHIFT) begin
      reg_sel = 2'd2;
    end else begin
      reg_sel = 2'd3;
    end
  endfunction

  assign pins_async = {parallel_pins_floating, address_pin_bit2, address_pin_bit1,
                       address_pin_bit0, parallel_control_inputs, mode_select,
                       latch_strobe, serial_data, serial_clock};

  // Data and clock go through the same stages, so their sampled order holds.
  sac_sync2 #(.W(PIN_W)) u_sync (
    .clk(clk),
    .rst(rst),
    .d(pins_async),
    .q(pins_s)
  );

  assign sclk_s = pins_s[0];
  assign sdata_s = pins_s[1];
  assign le_s = pins_s[2];
  assign serial_mode_s = pins_s[3];
  assign par_s = pins_s[10:4];
  assign addr_s = pins_s[13:11];
  assign float_s = pins_s[14];
  // Floating pins read as low, so a parallel strobe or direct mode sets minimum; serial mode ignores them.
  assign par_eff = float_s ? SAC_ATT_MIN : par_s;

  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_d_r <= 1'b0;
      le_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
      le_d_r <= le_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign le_rise = le_s & ~le_d_r;
  assign running = (state_r == SAC_ST_RUN);
  assign hold_upd = ctrl_r[SAC_CTRL_HOLD_BIT];

  assign addr_match = (shreg_r[SAC_ADDR_LSB +: SAC_ADDR_W] == addr_s);
  assign direct_follow = running & ~serial_mode_s & le_s & ~hold_upd;

  // First word ends in the low byte.
  always_ff @(posedge clk) begin
    if (rst) begin
      shreg_r <= '0;
    end else if (running && serial_mode_s && sclk_rise && !le_s) begin
      shreg_r <= {sdata_s, shreg_r[SAC_SHIFT_W-1:1]};
    end
  end

  // Start-up sequencer. The strap is caught only after the pins have settled.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= SAC_ST_INIT;
      cnt_r <= SAC_CNT_W'(SAC_INIT_CYC - 1);
    end else begin
      case (state_r)
        SAC_ST_INIT: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end else if (!serial_mode_s && le_s) begin
            state_r <= SAC_ST_HOLD;
            cnt_r <= SAC_CNT_W'(POWERUP_CYCLES - 1);
          end else begin
            state_r <= SAC_ST_RUN;
          end
        end
        SAC_ST_HOLD: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end else begin
            state_r <= SAC_ST_RUN;
          end
        end
        default: begin
          state_r <= SAC_ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      word_r <= {1'b0, SAC_ATT_MAX};
    end else if (state_r == SAC_ST_HOLD && cnt_r == '0) begin
      word_r <= float_s ? {1'b0, SAC_ATT_MIN} : {1'b0, par_s};
    end else if (running && !hold_upd) begin
      if (serial_mode_s) begin
        if (le_rise && addr_match) begin
          word_r <= shreg_r[SAC_WORD_W-1:0];
        end
      end else if (direct_follow || le_rise) begin
        word_r <= {1'b0, par_eff};
      end
    end
  end

  assign attenuation_state = word_r[SAC_ATT_W-1:0];

  // Register write path: address and data may arrive in either order.
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (aw_got_r && w_got_r) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
    end
  end

  assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_got_r & ~s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= SAC_CTRL_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SAC_RESP_OKAY;
    end else if (aw_got_r && w_got_r) begin
      s_axi_bvalid <= 1'b1;
      if (reg_sel(awaddr_r) == 2'd0) begin
        s_axi_bresp <= SAC_RESP_OKAY;
        if (wstrb_r[0]) begin
          ctrl_r[SAC_CTRL_HOLD_BIT] <= wdata_r[SAC_CTRL_HOLD_BIT];
        end
      end else if (reg_sel(awaddr_r) == 2'd3) begin
        s_axi_bresp <= SAC_RESP_SLVERR;
      end else begin
        s_axi_bresp <= SAC_RESP_OKAY;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read path: one read at a time, answered the cycle after the address.
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= SAC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= SAC_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      if (reg_sel(s_axi_araddr) == 2'd0) begin
        s_axi_rdata <= ctrl_r;
      end else if (reg_sel(s_axi_araddr) == 2'd1) begin
        s_axi_rdata[SAC_WORD_W-1:0] <= word_r;
        s_axi_rdata[SAC_ST_SERIAL_BIT] <= serial_mode_s;
        s_axi_rdata[SAC_ST_BUSY_BIT] <= ~running;
      end else if (reg_sel(s_axi_araddr) == 2'd2) begin
        s_axi_rdata[SAC_SHIFT_W-1:0] <= shreg_r;
      end else begin
        s_axi_rresp <= SAC_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks on the behaviour above.
  sequence s_serial_latch;
    running && serial_mode_s && !hold_upd && le_rise;
  endsequence

  sequence s_par_latch;
    running && !serial_mode_s && !hold_upd && le_rise;
  endsequence

  AST_SHIFT_LSB: assert property (
    @(posedge clk) disable iff (rst)
    (running && serial_mode_s && sclk_rise && !le_s) |=>
      (shreg_r[SAC_SHIFT_W-1] == $past(sdata_s)) &&
      (shreg_r[SAC_SHIFT_W-2:0] == $past(shreg_r[SAC_SHIFT_W-1:1])))
    else $error("Serial bit not shifted in at the top.");

  AST_MATCH_APPLIES: assert property (
    @(posedge clk) disable iff (rst)
    (s_serial_latch and addr_match) |=>
      attenuation_state == $past(shreg_r[SAC_ATT_W-1:0]))
    else $error("Matching serial latch did not apply the word.");

  AST_MISMATCH_KEEPS: assert property (
    @(posedge clk) disable iff (rst)
    (s_serial_latch and !addr_match) |=> $stable(attenuation_state))
    else $error("Mismatching address changed the attenuation.");

  AST_SHIFT_NO_CHANGE: assert property (
    @(posedge clk) disable iff (rst)
    (running && serial_mode_s && !le_rise) ##1 (serial_mode_s && !le_rise)
      |=> $stable(attenuation_state))
    else $error("Attenuation changed without a rising strobe.");

  AST_LATCHED_CAPTURE: assert property (
    @(posedge clk) disable iff (rst)
    s_par_latch |=> attenuation_state == $past(par_eff))
    else $error("Parallel strobe did not capture the pins.");

  AST_DIRECT_FOLLOW: assert property (
    @(posedge clk) disable iff (rst)
    direct_follow ##1 direct_follow |=> attenuation_state == $past(par_eff, 1))
    else $error("Direct mode did not follow the pins.");

  AST_STARTUP_MAX: assert property (
    @(posedge clk) disable iff (rst)
    !running |-> attenuation_state == SAC_ATT_MAX)
    else $error("Attenuation not at maximum during start-up.");

  AST_HOLD_END: assert property (
    @(posedge clk) disable iff (rst)
    (state_r == SAC_ST_HOLD && cnt_r == '0) |=> running &&
      attenuation_state == ($past(float_s) ? SAC_ATT_MIN : $past(par_s)))
    else $error("Direct start-up did not adopt the preset.");

  AST_HOLD_STARTS: assert property (
    @(posedge clk) disable iff (rst)
    $rose(state_r == SAC_ST_HOLD) |-> cnt_r == SAC_CNT_W'(POWERUP_CYCLES - 1))
    else $error("Start-up hold loaded a wrong length.");

  AST_WRITE_RESP: assert property (
    @(posedge clk) disable iff (rst)
    (aw_got_r && w_got_r) |=> s_axi_bvalid ##1 (s_axi_bvalid || $past(s_axi_bready)))
    else $error("Write response missing or dropped early.");
endmodule
`default_nettype wire

// ### bench/sac_ctrl_model.sv
// Behavioural model of the outside controller on the serial and strobe pins.
// Assumes one bench process calls its tasks, each entered just after a clk edge.
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl_model (
  input wire logic clk,
  output logic serial_clock,
  output logic serial_data,
  output logic latch_strobe
);
  initial begin
    serial_clock = 1'b0;
    serial_data = 1'b1;
    latch_strobe = 1'b0;
  end
  task automatic send_word(input logic [7:0] att, input logic [7:0] adr);
    logic [15:0] w;
    w = {adr, att};
    for (int i = 0; i < 16; i++) begin
      serial_data <= w[i];
      repeat (16) @(posedge clk);
      serial_clock <= 1'b1;
      repeat (16) @(posedge clk);
      serial_clock <= 1'b0;
    end
    // A released data line shows the opposite level, so a stale bit is never trusted.
    serial_data <= ~w[15];
    repeat (4) @(posedge clk);
  endtask
  task automatic pulse();
    latch_strobe <= 1'b1;
    repeat (6) @(posedge clk);
    latch_strobe <= 1'b0;
    // Scaled rate gap.
    // Time runs scaled like the start-up hold, so the rate limit is a few cycles.
    repeat (6) @(posedge clk);
  endtask
  task automatic set_strobe(input logic v);
    latch_strobe <= v;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### bench/sac_step_attenuator_bench.sv
// Self-checking bench for the step attenuator control block.
// Assumes the controller model drives the serial pins and AXI4-Lite tasks reach registers.
`timescale 1ns/1ps
`default_nettype none
module sac_step_attenuator_bench;
  import sac_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sck, sdi, le, mode = 1'b0, flt = 1'b0;
  logic [6:0] pins = 7'h00;
  logic [2:0] adr = 3'h3;
  logic [6:0] state;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0000_0000, rd;
  logic [3:0] ws = 4'h0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic awr, wr, bv, arr, rv;
  logic [1:0] br, rr, resp;
  logic [31:0] r;
  int err_count = 0;
  int compares = 0;
  always #2.5 clk = ~clk;
  sac_ctrl_model sac_ctrl_model_inst (.clk(clk), .serial_clock(sck), .serial_data(sdi),
    .latch_strobe(le));
  sac_step_attenuator #(.POWERUP_CYCLES(20)) sac_step_attenuator_inst (.clk(clk), .rst(rst),
    .serial_clock(sck), .serial_data(sdi), .latch_strobe(le), .mode_select(mode),
    .parallel_control_inputs(pins), .address_pin_bit0(adr[0]), .address_pin_bit1(adr[1]),
    .address_pin_bit2(adr[2]), .parallel_pins_floating(flt), .attenuation_state(state),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rry));
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    int n;
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      resp = br;
      if (bv) break;
    end
    bry <= 1'b0;
    if (n == 50) begin
      err_count++;
      wrap_up();
    end
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int n;
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      r = rd;
      resp = rr;
      if (rv) break;
    end
    rry <= 1'b0;
    if (n == 50) begin
      err_count++;
      wrap_up();
    end
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  initial begin
    do_reset();
    chk("start", state, 32'h7F); // Start at maximum.
    pins <= 7'h49;
    repeat (8) @(posedge clk);
    chk("unlatched", state, 32'h7F); // Pins alone do nothing.
    sac_ctrl_model_inst.pulse();
    chk("latched", state, 32'h49); // Binary weights latched.
    $display("test latched parallel done");
    sac_ctrl_model_inst.set_strobe(1'b1);
    for (int i = 0; i < 7; i++) begin
      pins <= 7'h01 << i;
      repeat (6) @(posedge clk);
      chk("direct", state, 32'h1 << i); // Follows each weight.
    end
    sac_ctrl_model_inst.set_strobe(1'b0);
    $display("test direct parallel done");
    pins <= 7'h00;
    @(posedge clk);
    mode <= 1'b1;
    repeat (8) @(posedge clk);
    sac_ctrl_model_inst.send_word(8'h49, 8'hFB);
    axi_rd(SAC_REG_SHIFT);
    chk("shift", r, 32'h0000_FB49); // Word order and bit order.
    chk("while shifting", state, 32'h40); // No change before strobe.
    sac_ctrl_model_inst.pulse();
    chk("match", state, 32'h49); // Upper address ignored.
    axi_rd(SAC_REG_STATUS);
    chk("status", r, 32'h0000_0149); // Serial mode seen.
    sac_ctrl_model_inst.send_word(8'h0C, 8'h02);
    sac_ctrl_model_inst.pulse();
    chk("mismatch", state, 32'h49); // Other address ignored.
    $display("test serial done");
    axi_wr(SAC_REG_CTRL, 32'h0000_0001);
    chk("wr resp", resp, SAC_RESP_OKAY); // Write accepted.
    sac_ctrl_model_inst.send_word(8'h05, 8'h03);
    sac_ctrl_model_inst.pulse();
    chk("held", state, 32'h49); // Hold blocks the latch.
    axi_rd(SAC_REG_CTRL);
    chk("ctrl", r, 32'h0000_0001); // Hold bit reads back.
    axi_wr(SAC_REG_CTRL, 32'h0000_0000);
    sac_ctrl_model_inst.pulse();
    chk("released", state, 32'h05); // Latch after release.
    axi_wr(SAC_REG_CTRL, 32'h0000_0001, 4'hE);
    axi_rd(SAC_REG_CTRL);
    chk("lane off", r, 32'h0000_0000); // Byte lane 0 disabled.
    adr <= 3'h2;
    repeat (4) @(posedge clk);
    sac_ctrl_model_inst.pulse();
    chk("pins moved", state, 32'h05); // Old address now misses.
    sac_ctrl_model_inst.send_word(8'h0C, 8'hE2);
    sac_ctrl_model_inst.pulse();
    chk("new address", state, 32'h0C); // Address pins compared.
    axi_rd(8'h0C);
    chk("unmapped rd", {resp, r[29:0]}, {SAC_RESP_SLVERR, 30'h0}); // Error answer.
    axi_wr(8'h0C, 32'h0000_0001);
    chk("unmapped wr", resp, SAC_RESP_SLVERR); // Error answer.
    $display("test registers done");
    mode <= 1'b0;
    pins <= 7'h22;
    repeat (8) @(posedge clk);
    sac_ctrl_model_inst.pulse();
    chk("back to parallel", state, 32'h22); // Free switching.
    $display("test mode switch done");
    pins <= 7'h12;
    sac_ctrl_model_inst.set_strobe(1'b1);
    do_reset();
    chk("direct hold", state, 32'h7F); // Maximum during hold.
    repeat (40) @(posedge clk);
    chk("direct preset", state, 32'h12); // Preset adopted.
    flt <= 1'b1;
    do_reset();
    repeat (40) @(posedge clk);
    chk("floating", state, 32'h00); // Minimum when floating.
    $display("test start-up done");
    wrap_up();
  end
endmodule
`default_nettype wire
